// [core/iprb_pkg.sv]
// Purpose: shared constants and types for the interrupt priority bank
// Assumes: 16-bit registers on a plain strobe port, one word per index
// Notes: offsets are register indices on the local port
package iprb_pkg;
    localparam int unsigned IPRB_AW = 3;
    localparam int unsigned IPRB_DW = 16;
    localparam int unsigned IPRB_NREG = 6;
    localparam int unsigned IPRB_NSRC = 19;
    localparam logic [2:0] IPRB_OFS_CTRL_7 = 3'h0;
    localparam logic [2:0] IPRB_OFS_CTRL_8 = 3'h1;
    localparam logic [2:0] IPRB_OFS_CTRL_9 = 3'h2;
    localparam logic [2:0] IPRB_OFS_CTRL_10 = 3'h3;
    localparam logic [2:0] IPRB_OFS_CTRL_11 = 3'h4;
    localparam logic [2:0] IPRB_OFS_CTRL_12 = 3'h5;
    // field low-bit positions
    localparam int unsigned IPRB_POS_HI = 12;
    localparam int unsigned IPRB_POS_MH = 8;
    localparam int unsigned IPRB_POS_ML = 4;
    localparam int unsigned IPRB_POS_LO = 0;
    // implemented-bit masks per register
    localparam logic [15:0] IPRB_MASK_FULL = 16'h7777;
    localparam logic [15:0] IPRB_MASK_10 = 16'h0777;
    localparam logic [15:0] IPRB_MASK_MID = 16'h0770;
    localparam logic [2:0] IPRB_PRIO_RST = 3'h4;
    localparam logic [15:0] IPRB_RST_FULL = 16'h4444;
    localparam logic [15:0] IPRB_RST_10 = 16'h0444;
    localparam logic [15:0] IPRB_RST_MID = 16'h0440;
    localparam logic [2:0] IPRB_PRIO_OFF = 3'h0;

    typedef logic [2:0] iprb_prio_t;

    typedef struct packed {
        logic [IPRB_AW-1:0] addr;
        logic [IPRB_DW-1:0] wdata;
        logic wr;
        logic rd;
    } iprb_req_s;

    // one decoded source: enable and level
    typedef struct packed {
        logic en;
        iprb_prio_t level;
    } iprb_src_s;

    typedef struct packed {
        iprb_prio_t uart2_tx_prio;
        iprb_prio_t uart2_rx_prio;
        iprb_prio_t ext_pin2_prio;
        iprb_prio_t timer5_prio;
        iprb_prio_t crypto_rollover_prio;
        iprb_prio_t crypto_buffer_free_prio;
        iprb_prio_t spi2_transmit_prio;
        iprb_prio_t spi2_general_prio;
        iprb_prio_t capture5_prio;
        iprb_prio_t capture4_prio;
        iprb_prio_t capture3_prio;
        iprb_prio_t dma_ch3_prio;
        iprb_prio_t compare6_prio;
        iprb_prio_t compare5_prio;
        iprb_prio_t capture6_prio;
        iprb_prio_t dma_ch4_prio;
        iprb_prio_t parallel_port_prio;
        iprb_prio_t i2c2_master_event_prio;
        iprb_prio_t i2c2_slave_event_prio;
    } iprb_fields_s;
endpackage

// [core/iprb_decode.sv]
// Purpose: turn one 3-bit priority code into enable and level
// Assumes: code 0 disables, 1..7 are levels with 7 highest
// Notes: purely combinational
`timescale 1ns/100ps
module iprb_decode
(
    input wire iprb_pkg::iprb_prio_t code,
    output iprb_pkg::iprb_src_s src
);
    import iprb_pkg::*;

    always_comb begin
        // zero code never reaches the processor
        src.en = (code != IPRB_PRIO_OFF);
        // code value is the level, 7 top and 1 bottom
        src.level = code;
    end
endmodule

// [core/iprb_bank.sv]
// Purpose: six interrupt priority control registers, 7 through 12
// Assumes: single clock, synchronous active-low reset, plain strobe port
// Notes: read data is registered and valid only the cycle after rd
`timescale 1ns/100ps
module iprb_bank
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire iprb_pkg::iprb_req_s req,
    output logic [iprb_pkg::IPRB_DW-1:0] rdata,
    output iprb_pkg::iprb_fields_s prio,
    output iprb_pkg::iprb_src_s [iprb_pkg::IPRB_NSRC-1:0] src
);
    import iprb_pkg::*;

    logic [IPRB_DW-1:0] ctrl7_r;
    logic [IPRB_DW-1:0] ctrl8_r;
    logic [IPRB_DW-1:0] ctrl9_r;
    logic [IPRB_DW-1:0] ctrl10_r;
    logic [IPRB_DW-1:0] ctrl11_r;
    logic [IPRB_DW-1:0] ctrl12_r;
    logic [IPRB_DW-1:0] rdata_r;
    logic [IPRB_DW-1:0] rdata_nxt;
    iprb_prio_t codes [IPRB_NSRC];

    // implemented-bit mask of a register index
    function automatic logic [15:0] reg_mask(input logic [2:0] a);
        case (a)
            IPRB_OFS_CTRL_7, IPRB_OFS_CTRL_8, IPRB_OFS_CTRL_9:
                reg_mask = IPRB_MASK_FULL;
            IPRB_OFS_CTRL_10: reg_mask = IPRB_MASK_10;
            IPRB_OFS_CTRL_11, IPRB_OFS_CTRL_12: reg_mask = IPRB_MASK_MID;
            default: reg_mask = 16'h0000;
        endcase
    endfunction

    function automatic iprb_prio_t fld(input logic [15:0] v,
                                       input int unsigned pos);
        fld = v[pos +: 3];
    endfunction

    function automatic logic hit(input iprb_req_s r, input logic [2:0] a);
        hit = r.wr && (r.addr == a);
    endfunction

    // masking on write drops unused bits
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl7_r <= IPRB_RST_FULL;
        end else if (hit(req, IPRB_OFS_CTRL_7)) begin
            ctrl7_r <= req.wdata & IPRB_MASK_FULL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl8_r <= IPRB_RST_FULL;
        end else if (hit(req, IPRB_OFS_CTRL_8)) begin
            ctrl8_r <= req.wdata & IPRB_MASK_FULL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl9_r <= IPRB_RST_FULL;
        end else if (hit(req, IPRB_OFS_CTRL_9)) begin
            ctrl9_r <= req.wdata & IPRB_MASK_FULL;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl10_r <= IPRB_RST_10;
        end else if (hit(req, IPRB_OFS_CTRL_10)) begin
            ctrl10_r <= req.wdata & IPRB_MASK_10;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl11_r <= IPRB_RST_MID;
        end else if (hit(req, IPRB_OFS_CTRL_11)) begin
            ctrl11_r <= req.wdata & IPRB_MASK_MID;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            ctrl12_r <= IPRB_RST_MID;
        end else if (hit(req, IPRB_OFS_CTRL_12)) begin
            ctrl12_r <= req.wdata & IPRB_MASK_MID;
        end
    end

    // unmapped indices read as zero; reads have no side effect
    always_comb begin
        rdata_nxt = '0;
        case (req.addr)
            IPRB_OFS_CTRL_7: rdata_nxt = ctrl7_r;
            IPRB_OFS_CTRL_8: rdata_nxt = ctrl8_r;
            IPRB_OFS_CTRL_9: rdata_nxt = ctrl9_r;
            IPRB_OFS_CTRL_10: rdata_nxt = ctrl10_r;
            IPRB_OFS_CTRL_11: rdata_nxt = ctrl11_r;
            IPRB_OFS_CTRL_12: rdata_nxt = ctrl12_r;
            default: rdata_nxt = '0;
        endcase
        // belt and braces: stored bits are already masked
        rdata_nxt = rdata_nxt & reg_mask(req.addr);
    end

    // data held at zero outside the answer cycle
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            rdata_r <= '0;
        end else if (req.rd) begin
            rdata_r <= rdata_nxt;
        end else begin
            rdata_r <= '0;
        end
    end

    assign rdata = rdata_r;

    always_comb begin
        prio.uart2_tx_prio = fld(ctrl7_r, IPRB_POS_HI);
        prio.uart2_rx_prio = fld(ctrl7_r, IPRB_POS_MH);
        prio.ext_pin2_prio = fld(ctrl7_r, IPRB_POS_ML);
        prio.timer5_prio = fld(ctrl7_r, IPRB_POS_LO);
        prio.crypto_rollover_prio = fld(ctrl8_r, IPRB_POS_HI);
        prio.crypto_buffer_free_prio = fld(ctrl8_r, IPRB_POS_MH);
        prio.spi2_transmit_prio = fld(ctrl8_r, IPRB_POS_ML);
        prio.spi2_general_prio = fld(ctrl8_r, IPRB_POS_LO);
        prio.capture5_prio = fld(ctrl9_r, IPRB_POS_HI);
        prio.capture4_prio = fld(ctrl9_r, IPRB_POS_MH);
        prio.capture3_prio = fld(ctrl9_r, IPRB_POS_ML);
        prio.dma_ch3_prio = fld(ctrl9_r, IPRB_POS_LO);
        prio.compare6_prio = fld(ctrl10_r, IPRB_POS_MH);
        prio.compare5_prio = fld(ctrl10_r, IPRB_POS_ML);
        prio.capture6_prio = fld(ctrl10_r, IPRB_POS_LO);
        prio.dma_ch4_prio = fld(ctrl11_r, IPRB_POS_MH);
        prio.parallel_port_prio = fld(ctrl11_r, IPRB_POS_ML);
        prio.i2c2_master_event_prio = fld(ctrl12_r, IPRB_POS_MH);
        prio.i2c2_slave_event_prio = fld(ctrl12_r, IPRB_POS_ML);
    end

    // src index 18 is uart2 tx, down to 0 for i2c2 slave (struct order)
    always_comb begin
        for (int i = 0; i < IPRB_NSRC; i++) begin
            codes[i] = prio[i*3 +: 3];
        end
    end

    for (genvar g = 0; g < IPRB_NSRC; g++) begin : g_dec
        iprb_decode u_dec (
            .code(codes[g]),
            .src(src[g])
        );
    end
endmodule

// [dv/iprb_bank_props.sv]
// Purpose: port checks for the priority bank
// Assumes: sees only the top module ports
// Notes: rdata is judged the cycle after a read strobe
`timescale 1ns/100ps
module iprb_bank_props
(
    input wire logic ref_clk,
    input wire logic rstn,
    input wire iprb_pkg::iprb_req_s req,
    input wire logic [iprb_pkg::IPRB_DW-1:0] rdata,
    input wire iprb_pkg::iprb_fields_s prio,
    input wire iprb_pkg::iprb_src_s [iprb_pkg::IPRB_NSRC-1:0] src
);
    import iprb_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    a_rdata_idle: assert property (
        !req.rd |=> rdata == 16'h0) else $error("rdata not idle");
    a_spacer_zero: assert property (
        (rdata & 16'h8888) == 16'h0) else $error("spacer bit set");
    a_top_unused: assert property (
        req.rd && req.addr >= 3'h3 |=> rdata[15:11] == 5'h0)
        else $error("upper bits set");
    a_mid_mask: assert property (
        req.rd && (req.addr == 3'h4 || req.addr == 3'h5)
        |=> (rdata & 16'hf88f) == 16'h0) else $error("mask broken");
    a_unmapped_rd: assert property (
        req.rd && req.addr > 3'h5 |=> rdata == 16'h0)
        else $error("unmapped read not zero");
    a_write_field: assert property (
        req.wr && req.addr == 3'h0
        |=> prio.uart2_tx_prio == $past(req.wdata[14:12]))
        else $error("field not written");
    a_hold_prio: assert property (
        !req.wr |=> $stable(prio)) else $error("field moved");
    a_src_off: assert property (
        src[18].en == (prio.uart2_tx_prio != 3'h0))
        else $error("enable wrong");
    a_src_level: assert property (
        src[7].level == prio.dma_ch3_prio) else $error("level wrong");
    a_reset_lvl: assert property (
        $rose(rstn) |-> prio.timer5_prio == 3'h4
        && prio.i2c2_slave_event_prio == 3'h4)
        else $error("reset level wrong");
    c_read: cover property (req.rd ##1 rdata != 16'h0);
    c_write: cover property (req.wr && req.addr == 3'h5);
    c_off: cover property (!src[0].en);
    c_back2back: cover property (req.wr ##1 req.rd);
endmodule
bind iprb_bank iprb_bank_props i_props(.ref_clk(ref_clk), .rstn(rstn),
    .req(req), .rdata(rdata), .prio(prio), .src(src));

// [dv/testbench.sv]
// Purpose: directed bench for the priority bank
// Assumes: a gap cycle between requests, except in the burst scenario
// Notes: expectations come from the field layout
`timescale 1ns/100ps
module testbench;
    import iprb_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    iprb_req_s req = '0;
    logic [15:0] rdata;
    iprb_fields_s prio;
    iprb_src_s [IPRB_NSRC-1:0] src;
    int err_count = 0;
    int tests_run = 0;
    int cycles = 0;
    iprb_bank i_iprb_bank(.ref_clk(ref_clk), .rstn(rstn), .req(req),
        .rdata(rdata), .prio(prio), .src(src));
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end
    // run needs about 280 cycles; the margin covers slow reads
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count = err_count + 1;
            complete_run();
        end
    end
    task automatic complete_run();
        if (err_count == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic cmp(string name, logic [63:0] exp, logic [63:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask
    // a gap cycle follows every request, so strobes never collide
    task automatic bus(logic w, logic [2:0] a, logic [15:0] d,
            logic [15:0] exp);
        @(posedge ref_clk);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge ref_clk);
        req.wr <= 1'b0;
        req.rd <= 1'b0;
        #1;
        if (!w) cmp("rdata", {48'h0, exp}, {48'h0, rdata});
    endtask
    task automatic t_reset();
        logic [15:0] rv [6] = '{16'h4444, 16'h4444, 16'h4444, 16'h0444,
            16'h0440, 16'h0440};
        for (int i = 0; i < 6; i++)
            bus(1'b0, 3'(i), 16'h0, rv[i]);
        cmp("src0", 64'hc, src[0]);
    endtask
    // spacer bits are written as ones to prove they are dropped
    task automatic t_codes();
        logic [15:0] w;
        logic [63:0] e;
        for (int c = 0; c < 8; c++) begin
            w = {4{1'b1, 3'(c)}};
            e = {60'h0, c != 0, 3'(c)};
            for (int i = 0; i < 6; i++)
                bus(1'b1, 3'(i), w, 16'h0);
            bus(1'b0, 3'h0, 16'h0, w & 16'h7777);
            bus(1'b0, 3'h1, 16'h0, w & 16'h7777);
            bus(1'b0, 3'h2, 16'h0, w & 16'h7777);
            bus(1'b0, 3'h3, 16'h0, w & 16'h0777);
            bus(1'b0, 3'h4, 16'h0, w & 16'h0770);
            bus(1'b0, 3'h5, 16'h0, w & 16'h0770);
            bus(1'b0, 3'h7, 16'h0, 16'h0);
            for (int s = 0; s < 19; s++)
                cmp("src", e, src[s]);
        end
    endtask
    task automatic t_fields();
        logic [15:0] v [6] = '{16'h1234, 16'h5671, 16'h2345, 16'h0671,
            16'h0230, 16'h0450};
        logic [63:0] ef;
        ef = {7'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2,
            3'h3, 3'h4, 3'h5, 3'h6, 3'h7, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5};
        for (int i = 0; i < 6; i++)
            bus(1'b1, 3'(i), v[i], 16'h0);
        bus(1'b1, 3'h6, 16'h7777, 16'h0);
        cmp("prio", ef, prio);
        bus(1'b0, 3'h5, 16'h0, 16'h0450);
    endtask
    // strobes with no gap: a read sees the write just before it
    task automatic t_burst();
        @(posedge ref_clk);
        req <= '{addr: 3'h2, wdata: 16'hffff, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
        req <= '{addr: 3'h2, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        req <= '{addr: 3'h4, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
        #1;
        cmp("rdata", 64'h7777, rdata);
        @(posedge ref_clk);
        req.rd <= 1'b0;
        #1;
        cmp("rdata", 64'h0230, rdata);
        @(posedge ref_clk);
        #1;
        cmp("rdata", 64'h0, rdata);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        t_codes();
        t_fields();
        t_burst();
        @(posedge ref_clk);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        t_reset();
        complete_run();
    end
endmodule
